/* shared/xie_pkg.sv */
// constants and types for the exclusive-or execute block
package xie_pkg;
   // ****************************************
   // instruction word layout
   // ****************************************
   localparam int          XIE_IW_W        = 14;
   localparam int          XIE_OPC_HI      = 13;
   localparam int          XIE_OPC_LO      = 8;
   localparam int          XIE_DEST_BIT    = 7;
   localparam int          XIE_LIT_HI      = 7;
   localparam int          XIE_IDX_HI      = 6;
   localparam logic [5:0]  XIE_OPC_XOR_IMM = 6'h3A;
   localparam logic [5:0]  XIE_OPC_XOR_REG = 6'h06;
   // ****************************************
   // reset values and phase count
   // ****************************************
   localparam logic [7:0]  XIE_ACC_RST     = 8'h00;
   localparam logic [13:0] XIE_IW_RST      = 14'h0000;
   localparam int          XIE_PHASES      = 4;

   typedef enum logic [1:0] {
      XIE_Q1 = 2'b00,
      XIE_Q2 = 2'b01,
      XIE_Q3 = 2'b10,
      XIE_Q4 = 2'b11
   } xie_phase_t;

   typedef enum logic [1:0] {
      XIE_OP_NONE = 2'b00,
      XIE_OP_IMM  = 2'b01,
      XIE_OP_REG  = 2'b10
   } xie_op_t;
endpackage : xie_pkg

/* hdl/xie_decode.sv */
// combinational opcode decoder for the two exclusive-or forms
`timescale 1ns/1ps
module xie_decode
   import xie_pkg::*;
(
   input  wire logic [13:0] instr,
   output xie_op_t          op,
   output logic             dest_reg,
   output logic [6:0]       reg_idx,
   output logic [7:0]       literal
);
   always_comb begin
      op = XIE_OP_NONE;
      if (instr[XIE_OPC_HI:XIE_OPC_LO] == XIE_OPC_XOR_IMM) begin
         op = XIE_OP_IMM;
      end else if (instr[XIE_OPC_HI:XIE_OPC_LO] == XIE_OPC_XOR_REG) begin
         op = XIE_OP_REG;
      end
   end
   assign dest_reg = instr[XIE_DEST_BIT];
   assign reg_idx  = instr[XIE_IDX_HI:0];
   assign literal  = instr[XIE_LIT_HI:0];
endmodule // xie_decode

/* hdl/xie_exec.sv */
// four-phase execute unit for the immediate and register exclusive-or forms
`timescale 1ns/1ps
// Functional notes
// - immediate form: accumulator xor literal into accumulator
// - opcode 11 1010 selects immediate form
// - opcode 00 0110, bit 7 dest, index
// - dest clear: result to accumulator only
// - dest set: result to register only
// - four cycles: latch, decode and read, process, write
module xie_exec
   import xie_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic [13:0] instr,
   input  wire logic [7:0]  rf_rdata,
   output logic [1:0]       phase,
   output logic [6:0]       rf_addr,
   output logic             rf_we,
   output logic [7:0]       rf_wdata,
   output logic [7:0]       acc,
   output logic             zero_we,
   output logic             zero_val,
   output logic             done
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      xie_phase_t  ph;
      logic [13:0] iw;
      xie_op_t     op;
      logic        dst;
      logic [7:0]  opnd;
      logic [7:0]  res;
      logic [7:0]  acc;
      logic [6:0]  addr;
      logic        we;
      logic [7:0]  wdata;
      logic        zwe;
      logic        zval;
      logic        done;
   } xie_state_t;

   xie_state_t st_r;
   xie_state_t st_nxt;
   xie_op_t    dec_op;
   logic       dec_dst;
   logic [6:0] dec_idx;
   logic [7:0] dec_lit;

   xie_decode u_dec (
      .instr    (st_r.iw),
      .op       (dec_op),
      .dest_reg (dec_dst),
      .reg_idx  (dec_idx),
      .literal  (dec_lit)
   );

   // ****************************************
   // phase sequencing and datapath
   // ****************************************
   always_comb begin
      st_nxt      = st_r;
      st_nxt.we   = 1'b0;
      st_nxt.zwe  = 1'b0;
      st_nxt.done = 1'b0;
      case (st_r.ph)
         XIE_Q1: begin
            st_nxt.iw   = instr;
            st_nxt.addr = instr[XIE_IDX_HI:0];
            st_nxt.ph = XIE_Q2;
         end
         XIE_Q2: begin
            st_nxt.op   = dec_op;
            st_nxt.dst  = dec_dst;
            st_nxt.addr = dec_idx;
            st_nxt.opnd = (dec_op == XIE_OP_IMM) ? dec_lit : rf_rdata;
            st_nxt.ph   = XIE_Q3;
         end
         XIE_Q3: begin
            st_nxt.res = st_r.acc ^ st_r.opnd;
            st_nxt.ph  = XIE_Q4;
         end
         XIE_Q4: begin
            st_nxt.done = 1'b1;
            st_nxt.ph   = XIE_Q1;
            if (st_r.op != XIE_OP_NONE) begin
               st_nxt.zwe  = 1'b1;
               st_nxt.zval = (st_r.res == 8'h00);
            end
            if (st_r.op == XIE_OP_IMM) begin
               st_nxt.acc = st_r.res;
            end else if (st_r.op == XIE_OP_REG && !st_r.dst) begin
               st_nxt.acc = st_r.res;
            end else if (st_r.op == XIE_OP_REG) begin
               st_nxt.we    = 1'b1;
               st_nxt.wdata = st_r.res;
            end
         end
         default: st_nxt.ph = XIE_Q1;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_r       <= '0;
         st_r.ph    <= XIE_Q1;
         st_r.iw    <= XIE_IW_RST;
         st_r.op    <= XIE_OP_NONE;
         st_r.acc   <= XIE_ACC_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign phase    = st_r.ph;
   assign rf_addr  = st_r.addr;
   assign rf_we    = st_r.we;
   assign rf_wdata = st_r.wdata;
   assign acc      = st_r.acc;
   assign zero_we  = st_r.zwe;
   assign zero_val = st_r.zval;
   assign done     = st_r.done;

   // ****************************************
   // checks
   // ****************************************
   property p_done_period;
      @(posedge clk_sys) disable iff (!resetn)
      done |=> !done[*3] ##1 done;
   endproperty
   a_done_period: assert property (p_done_period) else $error("done not every 4 cycles");

   property p_imm_result;
      @(posedge clk_sys) disable iff (!resetn)
      (st_r.ph == XIE_Q4 && st_r.op == XIE_OP_IMM) |=> (acc == $past(st_r.acc ^ st_r.opnd));
   endproperty
   a_imm_result: assert property (p_imm_result) else $error("immediate result wrong");

   property p_imm_decode;
      @(posedge clk_sys) disable iff (!resetn)
      (st_r.ph == XIE_Q2 && st_r.iw[XIE_OPC_HI:XIE_OPC_LO] == XIE_OPC_XOR_IMM)
         |=> (st_r.op == XIE_OP_IMM);
   endproperty
   a_imm_decode: assert property (p_imm_decode) else $error("immediate not decoded");

   property p_reg_decode;
      @(posedge clk_sys) disable iff (!resetn)
      (st_r.ph == XIE_Q2 && st_r.iw[XIE_OPC_HI:XIE_OPC_LO] == XIE_OPC_XOR_REG)
         |=> (st_r.op == XIE_OP_REG && rf_addr == $past(st_r.iw[XIE_IDX_HI:0]));
   endproperty
   a_reg_decode: assert property (p_reg_decode) else $error("register form not decoded");

   property p_reg_to_acc;
      @(posedge clk_sys) disable iff (!resetn)
      (st_r.ph == XIE_Q4 && st_r.op == XIE_OP_REG && !st_r.dst)
         |=> (!rf_we && acc == $past(st_r.res));
   endproperty
   a_reg_to_acc: assert property (p_reg_to_acc) else $error("acc dest wrong");

   property p_reg_to_rf;
      @(posedge clk_sys) disable iff (!resetn)
      (st_r.ph == XIE_Q4 && st_r.op == XIE_OP_REG && st_r.dst)
         |=> (rf_we && rf_wdata == $past(st_r.res) && $stable(acc));
   endproperty
   a_reg_to_rf: assert property (p_reg_to_rf) else $error("register dest wrong");

   property p_zero_flag;
      @(posedge clk_sys) disable iff (!resetn)
      zero_we |-> (zero_val == (rf_we ? (rf_wdata == 8'h00) : (acc == 8'h00)));
   endproperty
   a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

   property p_we_with_done;
      @(posedge clk_sys) disable iff (!resetn)
      (rf_we || zero_we) |-> done;
   endproperty
   a_we_with_done: assert property (p_we_with_done) else $error("write outside Q4");

   // ****************************************
   // phase, address and no-op checks
   // ****************************************
   property p_phase_step;
      @(posedge clk_sys) disable iff (!resetn)
      $past(resetn) |-> (phase == 2'($past(phase) + 2'h1));
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("phase step wrong");

   property p_rf_addr_q2;
      @(posedge clk_sys) disable iff (!resetn)
      (st_r.ph == XIE_Q2) |-> (rf_addr == st_r.iw[XIE_IDX_HI:0]);
   endproperty
   a_rf_addr_q2: assert property (p_rf_addr_q2) else $error("read index not shown");

   property p_imm_no_rf;
      @(posedge clk_sys) disable iff (!resetn)
      (st_r.ph == XIE_Q4 && st_r.op == XIE_OP_IMM) |=> (!rf_we && zero_we);
   endproperty
   a_imm_no_rf: assert property (p_imm_no_rf) else $error("immediate wrote register");

   property p_nop_quiet;
      @(posedge clk_sys) disable iff (!resetn)
      (st_r.ph == XIE_Q4 && st_r.op == XIE_OP_NONE)
         |=> (!rf_we && !zero_we && $stable(acc));
   endproperty
   a_nop_quiet: assert property (p_nop_quiet) else $error("other opcode changed state");

   property p_acc_at_q4;
      @(posedge clk_sys) disable iff (!resetn)
      $changed(acc) |-> done;
   endproperty
   a_acc_at_q4: assert property (p_acc_at_q4) else $error("acc changed outside Q4");

   property p_zero_result;
      @(posedge clk_sys) disable iff (!resetn)
      (st_r.ph == XIE_Q4 && st_r.op != XIE_OP_NONE)
         |=> (zero_we && zero_val == ($past(st_r.res) == 8'h00));
   endproperty
   a_zero_result: assert property (p_zero_result) else $error("zero flag not from result");

   c_imm: cover property (@(posedge clk_sys) disable iff (!resetn)
      done && zero_we && !rf_we);
   c_rf:  cover property (@(posedge clk_sys) disable iff (!resetn) rf_we);
   c_zero: cover property (@(posedge clk_sys) disable iff (!resetn) zero_we && zero_val);
   c_nop: cover property (@(posedge clk_sys) disable iff (!resetn) done && !zero_we);
endmodule // xie_exec

/* verif/tb_top.sv */
// self-checking bench for the exclusive-or execute block
`timescale 1ns/1ps
module tb_top;
   import xie_pkg::*;
   typedef struct packed {
      logic [7:0] acc;
      logic       we;
      logic [7:0] wd;
      logic [6:0] ad;
      logic       zw;
      logic       zv;
   } xie_exp_t;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [7:0]  rf_rdata = 8'h00;
   logic [1:0]  phase;
   logic [6:0]  rf_addr;
   logic        rf_we;
   logic [7:0]  rf_wdata;
   logic [7:0]  acc;
   logic        zero_we;
   logic        zero_val;
   logic        done;
   int          miscompares = 0;
   int          checks = 0;
   int          gap = 0;
   bit          seen = 0;
   logic [7:0]  acc_m = XIE_ACC_RST;
   xie_exp_t    q[$];
   xie_exp_t    e;

   xie_exec i_xie_exec (.clk_sys(clk_sys), .resetn(resetn), .instr(instr),
      .rf_rdata(rf_rdata), .phase(phase), .rf_addr(rf_addr), .rf_we(rf_we),
      .rf_wdata(rf_wdata), .acc(acc), .zero_we(zero_we), .zero_val(zero_val), .done(done));

   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic check(input string nm, input logic [7:0] ex, input logic [7:0] got);
      checks++;
      if (got !== ex) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ****************************************
   // issue one word in the next cycle slot
   // ****************************************
   task automatic issue(input logic [13:0] w, input logic [7:0] rd);
      int         n;
      xie_exp_t   x;
      logic [7:0] r;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (phase !== 2'b11 && n < 9);
      if (phase !== 2'b11) begin
         miscompares++;
         end_of_test();
      end
      @(posedge clk_sys);
      instr <= w;
      rf_rdata <= rd;
      x = '0;
      x.acc = acc_m;
      r = (w[13:8] == XIE_OPC_XOR_IMM) ? acc_m ^ w[7:0] : acc_m ^ rd;
      x.zw = (w[13:8] == XIE_OPC_XOR_IMM) || (w[13:8] == XIE_OPC_XOR_REG);
      x.zv = (r == 8'h00);
      if (w[13:8] == XIE_OPC_XOR_REG && w[7]) begin
         x.we = 1'b1;
         x.wd = r;
         x.ad = w[6:0];
      end else if (x.zw) begin
         x.acc = r;
      end
      acc_m = x.acc;
      q.push_back(x);
   endtask

   // ****************************************
   // retirement monitor
   // ****************************************
   always @(negedge clk_sys) begin
      gap = gap + 1;
      if (resetn && done === 1'b1) begin
         e = (q.size() > 0) ? q.pop_front() : '1;
         check("acc", e.acc, acc);
         check("rf_we", {7'h00, e.we}, {7'h00, rf_we});
         if (e.we) check("rf_wdata", e.wd, rf_wdata);
         if (e.we) check("rf_addr", {1'b0, e.ad}, {1'b0, rf_addr});
         check("zero_we", {7'h00, e.zw}, {7'h00, zero_we});
         if (e.zw) check("zero_val", {7'h00, e.zv}, {7'h00, zero_val});
         if (seen) check("cycle gap", 8'(XIE_PHASES), gap[7:0]);
         seen = 1;
         gap = 0;
      end else if (resetn) begin
         check("stray strobe", 8'h00, {6'h00, rf_we, zero_we});
      end
   end

   // ****************************************
   // retire the scenario behind a no-op word
   // ****************************************
   task automatic settle;
      issue(14'h0000, 8'h00);
      repeat (2) @(negedge clk_sys);
      check("pending", 8'h01, 8'(q.size()));
      check("phase", 8'(XIE_Q2), {6'h00, phase});
      check("rf_addr in Q2", 8'h00, {1'b0, rf_addr});
   endtask

   task automatic t_imm;
      issue({XIE_OPC_XOR_IMM, 8'hB5}, 8'h00);
      issue({XIE_OPC_XOR_IMM, 8'hAF}, 8'h00);
      issue({XIE_OPC_XOR_IMM, 8'hFF}, 8'h00);
      issue({XIE_OPC_XOR_IMM, acc_m}, 8'h00);
      settle();
      $display("test immediate form done");
   endtask

   task automatic t_reg;
      issue({XIE_OPC_XOR_REG, 1'b0, 7'h00}, 8'hB5);
      issue({XIE_OPC_XOR_REG, 1'b1, 7'h7F}, 8'hAF);
      issue({XIE_OPC_XOR_REG, 1'b1, 7'h2A}, acc_m);
      issue({XIE_OPC_XOR_REG, 1'b0, 7'h55}, 8'h00);
      settle();
      $display("test register form done");
   endtask

   task automatic t_noop;
      logic [5:0] ops [4] = '{6'h0E, 6'h3B, 6'h07, 6'h1A};
      foreach (ops[i]) issue({ops[i], 8'hFF}, 8'h5A);
      settle();
      $display("test other opcodes done");
   endtask

   initial begin
      int n;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      q.push_back('0);
      t_imm();
      t_reg();
      t_noop();
      n = 0;
      while (q.size() > 0 && n < 12) begin
         @(negedge clk_sys);
         n++;
      end
      if (q.size() > 0) miscompares++;
      end_of_test();
   end
endmodule // tb_top
